// ===== i2c_target_wake_sleep.sv
// Purpose: serial-bus target of a gas sensor with wake and sleep handling
// Assumes: scl and sda come from pins; open-drain drive through enables
// Notes: sleep here means the bus engine refuses its address
`timescale 1ns/1ps
module i2c_target_wake_sleep #(
    parameter int unsigned TIMEOUT_CYCLES = i2c_wake_pkg::TIMEOUT_CYC,
    parameter int unsigned RAM_WR_CYCLES = i2c_wake_pkg::RAM_WR_CYC,
    parameter int unsigned EE_SHORT_CYCLES = i2c_wake_pkg::EE_SHORT_CYC,
    parameter int unsigned EE_LONG_CYCLES = i2c_wake_pkg::EE_LONG_CYC
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_cfg_valid,
    input wire logic [6:0] addr_cfg,
    input wire logic ee_long_variant,
    output logic awake,
    output i2c_wake_pkg::reg_write_type reg_write
);
    import i2c_wake_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge finding
    pins_type s1_q, s2_q, prev_q;
    logic scl_rise, scl_fall, sda_rise, sda_fall, start_c, stop_c;

    // two flops per pin, then one more stage for edges
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            s1_q <= '{scl: 1'b1, sda: 1'b1};
            s2_q <= '{scl: 1'b1, sda: 1'b1};
            prev_q <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            s1_q <= '{scl: scl_in, sda: sda_in};
            s2_q <= s1_q;
            prev_q <= s2_q;
        end
    end

    // bus events; start and stop need scl high on both samples
    assign scl_rise = s2_q.scl & ~prev_q.scl;
    assign scl_fall = ~s2_q.scl & prev_q.scl;
    assign sda_rise = s2_q.sda & ~prev_q.sda;
    assign sda_fall = ~s2_q.sda & prev_q.sda;
    assign start_c = sda_fall & s2_q.scl & prev_q.scl;
    assign stop_c = sda_rise & s2_q.scl & prev_q.scl;

    ////////////////////////////////////////////////////////////////////////
    // helpers
    // stretch length picked by the kind of storage behind an index
    function automatic logic [STR_W-1:0] stretch_len(
        input logic [7:0] idx,
        input logic long_v
    );
        logic [STR_W-1:0] len;
        len = STR_W'(RAM_WR_CYCLES);
        if (idx >= NV_BASE) begin
            len = long_v ? STR_W'(EE_LONG_CYCLES)
                         : STR_W'(EE_SHORT_CYCLES);
        end
        return len;
    endfunction : stretch_len

    ////////////////////////////////////////////////////////////////////////
    // byte engine, sleep state and timers
    state_type st_q, st_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d, ptr_q, ptr_d, mem_rdata;
    logic idx_q, idx_d, rw_q, rw_d, mack_q, mack_d, asleep_q, asleep_d;
    logic nack_q, nack_d, done_q, done_d, sda_oe_q, sda_oe_d;
    logic scl_oe_q, scl_oe_d, kick, mem_we;
    logic [TMR_W-1:0] tmr_q, tmr_d;
    logic [STR_W-1:0] str_q, str_d;
    reg_write_type wr_q, wr_d;
    logic [6:0] my_addr;

    assign my_addr = addr_cfg_valid ? addr_cfg : DEFAULT_ADDR;

    // next values of the whole engine
    always_comb begin
        st_d = st_q;
        bit_d = bit_q;
        sh_d = sh_q;
        ptr_d = ptr_q;
        idx_d = idx_q;
        rw_d = rw_q;
        mack_d = mack_q;
        asleep_d = asleep_q;
        nack_d = nack_q;
        done_d = done_q;
        sda_oe_d = sda_oe_q;
        scl_oe_d = scl_oe_q;
        str_d = str_q;
        wr_d = '{valid: 1'b0, index: ptr_q, data: sh_q};
        kick = 1'b0;
        mem_we = 1'b0;
        if (start_c) begin
            st_d = ST_ADDR; // only a controller start opens a frame
            bit_d = '0;
            idx_d = 1'b1;
            sda_oe_d = 1'b0;
            scl_oe_d = 1'b0;
            nack_d = asleep_q; // asleep when the frame began
        end else if (stop_c) begin
            st_d = ST_IDLE;
            sda_oe_d = 1'b0;
            scl_oe_d = 1'b0;
            done_d = 1'b0;
            asleep_d = asleep_q | done_q; // sequence complete
        end else begin
            unique case (st_q)
                ST_IDLE, ST_IGNORE: begin
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], s2_q.sda};
                        bit_d = bit_q + 4'h1;
                    end else if (scl_fall && bit_q == BYTE_BITS) begin
                        kick = 1'b1;
                        if (sh_q[7:1] == my_addr && !nack_q) begin
                            sda_oe_d = 1'b1;
                            rw_d = sh_q[0];
                            st_d = ST_ADDR_ACK;
                        end else begin
                            st_d = ST_IGNORE;
                        end
                    end
                end
                ST_ADDR_ACK, ST_RD_ACK: begin
                    if (scl_rise && st_q == ST_RD_ACK) begin
                        mack_d = ~s2_q.sda;
                    end else if (scl_fall) begin
                        bit_d = '0;
                        if (st_q == ST_RD_ACK && !mack_q) begin
                            st_d = ST_IGNORE; // controller ends read
                        end else if (rw_q == DIR_READ) begin
                            sh_d = mem_rdata; // from last index
                            ptr_d = ptr_q + 8'h01;
                            sda_oe_d = ~mem_rdata[7];
                            st_d = ST_RD_BYTE;
                        end else begin
                            sda_oe_d = 1'b0;
                            st_d = ST_WR_BYTE;
                        end
                    end
                end
                ST_WR_BYTE: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], s2_q.sda};
                        bit_d = bit_q + 4'h1;
                    end else if (scl_fall && bit_q == BYTE_BITS) begin
                        kick = 1'b1;
                        sda_oe_d = 1'b1;
                        bit_d = '0;
                        if (idx_q) begin
                            ptr_d = sh_q; // first byte selects index
                            idx_d = 1'b0;
                            st_d = ST_WR_ACK;
                        end else begin
                            mem_we = 1'b1;
                            wr_d = '{valid: 1'b1, index: ptr_q, data: sh_q};
                            done_d = 1'b1;
                            scl_oe_d = 1'b1; // hold scl to evaluate
                            str_d = '0;
                            st_d = ST_STRETCH;
                        end
                    end
                end
                ST_STRETCH: begin
                    str_d = str_q + 1'b1;
                    if (str_q >= stretch_len(ptr_q, ee_long_variant)
                            - 1'b1) begin
                        scl_oe_d = 1'b0;
                        ptr_d = ptr_q + 8'h01; // consecutive index
                        st_d = ST_WR_ACK;
                    end
                end
                ST_WR_ACK: begin
                    if (scl_fall) begin
                        sda_oe_d = 1'b0;
                        st_d = ST_WR_BYTE;
                    end
                end
                ST_RD_BYTE: begin
                    if (scl_fall) begin
                        bit_d = bit_q + 4'h1;
                        if (bit_q == LAST_OUT_BIT) begin
                            kick = 1'b1;
                            done_d = 1'b1;
                            sda_oe_d = 1'b0;
                            st_d = ST_RD_ACK;
                        end else begin
                            sh_d = {sh_q[6:0], 1'b0};
                            sda_oe_d = ~sh_q[6];
                        end
                    end
                end
                default: begin
                    st_d = ST_IDLE;
                end
            endcase
        end
        // wake, inactivity timer and timeout
        tmr_d = '0;
        if (asleep_q) begin
            asleep_d = ~sda_fall; // a falling sda edge wakes
        end else if (st_q != ST_STRETCH && !kick && !sda_rise
                && !sda_fall) begin
            tmr_d = tmr_q + 1'b1;
            if (tmr_q >= TMR_W'(TIMEOUT_CYCLES - 1)) begin
                asleep_d = 1'b1;
                st_d = ST_IDLE;
                sda_oe_d = 1'b0;
                scl_oe_d = 1'b0;
                done_d = 1'b0;
                tmr_d = '0;
            end
        end
    end

    // register the engine
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            st_q <= ST_IDLE;
            bit_q <= '0;
            sh_q <= '0;
            ptr_q <= '0;
            idx_q <= 1'b0;
            rw_q <= 1'b0;
            mack_q <= 1'b0;
            asleep_q <= 1'b1;
            nack_q <= 1'b1;
            done_q <= 1'b0;
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b0;
            tmr_q <= '0;
            str_q <= '0;
            wr_q <= '0;
        end else begin
            st_q <= st_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            ptr_q <= ptr_d;
            idx_q <= idx_d;
            rw_q <= rw_d;
            mack_q <= mack_d;
            asleep_q <= asleep_d;
            nack_q <= nack_d;
            done_q <= done_d;
            sda_oe_q <= sda_oe_d;
            scl_oe_q <= scl_oe_d;
            tmr_q <= tmr_d;
            str_q <= str_d;
            wr_q <= wr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register store and outputs
    // byte store addressed by the index pointer
    i2c_reg_mem u_mem (
        .ref_clk(ref_clk),
        .we(mem_we),
        .addr(ptr_q),
        .wdata(sh_q),
        .rdata(mem_rdata)
    );

    // open-drain pins only ever pull low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = scl_oe_q;
    assign sda_oe = sda_oe_q;
    assign awake = ~asleep_q;
    assign reg_write = wr_q;

endmodule : i2c_target_wake_sleep

// ===== i2c_wake_pkg.sv
// Purpose: shared constants and types of the serial-bus target with sleep
// Assumes: one 10 MHz clock; bus pins arrive asynchronously
// Notes: times are kept in their own unit, cycle counts are derived
package i2c_wake_pkg;

    // clock and bus rate
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned SCL_MAX_HZ = 100_000; // controller limit
    localparam int unsigned HZ_PER_KHZ = 1_000;
    localparam int unsigned HZ_PER_MHZ = 1_000_000;

    // inactivity timeout, longest time so rounded down
    localparam int unsigned TIMEOUT_MS = 15;
    localparam int unsigned TIMEOUT_CYC = CLK_HZ / HZ_PER_KHZ * TIMEOUT_MS;

    // clock-stretch bounds set by storage write time
    localparam int unsigned RAM_WR_US = 1000;
    localparam int unsigned EE_SHORT_US = 25000;
    localparam int unsigned EE_LONG_US = 107000;
    localparam int unsigned RAM_WR_CYC = CLK_HZ / HZ_PER_MHZ * RAM_WR_US;
    localparam int unsigned EE_SHORT_CYC = CLK_HZ / HZ_PER_MHZ * EE_SHORT_US;
    localparam int unsigned EE_LONG_CYC = CLK_HZ / HZ_PER_MHZ * EE_LONG_US;

    // counter widths
    localparam int TMR_W = 18;
    localparam int STR_W = 21;

    // addressing and register space
    localparam logic [6:0] DEFAULT_ADDR = 7'h68;
    localparam int IDX_W = 8;
    localparam int MEM_DEPTH = 256;
    localparam logic [7:0] NV_BASE = 8'h80; // index at and above is EE-backed
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_OUT_BIT = 4'h7;
    localparam logic DIR_READ = 1'b1;

    // synchronised bus pins
    typedef struct packed {
        logic scl;
        logic sda;
    } pins_type;

    // notice of a register write to the sensor core
    typedef struct packed {
        logic valid;
        logic [7:0] index;
        logic [7:0] data;
    } reg_write_type;

    // byte engine states, gray in the order declared
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h3,
        ST_WR_BYTE = 4'h2,
        ST_STRETCH = 4'h6,
        ST_WR_ACK = 4'h7,
        ST_RD_BYTE = 4'h5,
        ST_RD_ACK = 4'h4,
        ST_IGNORE = 4'hc
    } state_type;

endpackage : i2c_wake_pkg

// ===== i2c_reg_mem.sv
// Purpose: byte register store behind the bus target
// Assumes: single port, a read every cycle and also a write when we is set
// Notes: read data comes out of a register, one cycle after the address
`timescale 1ns/1ps
module i2c_reg_mem (
    input wire logic ref_clk,
    input wire logic we,
    input wire logic [i2c_wake_pkg::IDX_W-1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    import i2c_wake_pkg::*;

    logic [7:0] mem [MEM_DEPTH];

    // write then registered read
    always_ff @(posedge ref_clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end

endmodule : i2c_reg_mem

// ===== i2c_target_wake_sleep_monitor.sv
// Purpose: checker bound to the bus target with wake and sleep
// Assumes: one clock domain, pins seen ahead of the synchronisers
// Notes: stretch lengths follow the parameters handed on by the bind
`timescale 1ns/1ps
module i2c_target_wake_sleep_monitor #(
    parameter int unsigned RAM_WR_CYCLES = 2,
    parameter int unsigned EE_SHORT_CYCLES = 2,
    parameter int unsigned EE_LONG_CYCLES = 2
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic ee_long_variant,
    input wire logic awake,
    input wire i2c_wake_pkg::reg_write_type reg_write
);
    import i2c_wake_pkg::*;
    localparam int RW1 = RAM_WR_CYCLES - 1;
    localparam int ES1 = EE_SHORT_CYCLES - 1;
    localparam int EL1 = EE_LONG_CYCLES - 1;
    logic data_q;
    logic data_d;
    logic nv;
    ////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // remembers a stored data byte within the current wake period
    always_comb begin
        data_d = awake && (data_q || reg_write.valid);
    end
    always_ff @(posedge ref_clk) begin
        data_q <= reset_n && data_d;
    end
    assign nv = reg_write.index >= NV_BASE;
    sequence s_stop; scl_in && $rose(sda_in); endsequence
    sequence s_wake_edge; !awake && scl_in && $fell(sda_in); endsequence
    property p_sda_low; $changed(sda_oe) |-> !scl_in; endproperty
    property p_ram; reg_write.valid && !nv |-> ##RW1 scl_oe ##1 !scl_oe;
    endproperty
    property p_ee_s;
        reg_write.valid && nv && !ee_long_variant |-> ##ES1 scl_oe ##1 !scl_oe;
    endproperty
    property p_ee_l;
        reg_write.valid && nv && ee_long_variant |-> ##EL1 scl_oe ##1 !scl_oe;
    endproperty
    property p_cause; $rose(scl_oe) |-> reg_write.valid; endproperty
    property p_wake; s_wake_edge |-> ##[1:5] awake; endproperty
    property p_quiet; !awake && !$fell(awake) |-> !sda_oe && !scl_oe;
    endproperty
    property p_sleep; s_stop ##0 data_q |-> ##[1:6] !awake; endproperty
    a_sda_low: assert property (p_sda_low)
        else $error("sda moved, scl high");
    a_ram: assert property (p_ram)
        else $error("ram stretch length");
    a_ee_s: assert property (p_ee_s)
        else $error("short ee stretch");
    a_ee_l: assert property (p_ee_l)
        else $error("long ee stretch");
    a_cause: assert property (p_cause)
        else $error("stretch w/o byte");
    a_wake: assert property (p_wake)
        else $error("no wake on sda fall");
    a_quiet: assert property (p_quiet)
        else $error("drive while asleep");
    a_sleep: assert property (p_sleep)
        else $error("awake after stop");
endmodule : i2c_target_wake_sleep_monitor

bind i2c_target_wake_sleep i2c_target_wake_sleep_monitor #(
    .RAM_WR_CYCLES(RAM_WR_CYCLES),
    .EE_SHORT_CYCLES(EE_SHORT_CYCLES),
    .EE_LONG_CYCLES(EE_LONG_CYCLES)
) mon (
    .ref_clk(ref_clk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in),
    .scl_oe(scl_oe), .sda_oe(sda_oe), .ee_long_variant(ee_long_variant),
    .awake(awake), .reg_write(reg_write)
);

// ===== i2c_ctrl_model.sv
// Purpose: bus controller model for the target's link
// Assumes: open-drain lines with pull-ups, resolved by the bench
// Notes: lines change only at falling edges of the sampling clock
`timescale 1ns/1ps
module i2c_ctrl_model #(
    parameter int HALF = 50
) (
    input wire logic ref_clk,
    input wire logic scl_w,
    input wire logic sda_w,
    output logic scl_low,
    output logic sda_low
);
    int stall;
    int hung;
    ////////////////////////////////////////
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        stall = 0;
        hung = 0;
    end
    // half a bit time keeps the rate at the standard limit
    task automatic hw;
        repeat (HALF) @(negedge ref_clk);
    endtask : hw
    // one clock pulse; a stretched clock is waited out, counted in stall
    task automatic clk_bit(input logic drv, output logic smp);
        sda_low = !drv;
        hw();
        scl_low = 1'b0;
        stall = 0;
        // let the released line settle before looking at it
        @(negedge ref_clk);
        while (scl_w !== 1'b1 && stall < 5000) begin
            @(negedge ref_clk);
            stall++;
        end
        if (stall >= 5000) hung++;
        hw();
        smp = sda_w;
        scl_low = 1'b1;
    endtask : clk_bit
    // start or repeated start, leaving scl low
    task automatic start;
        sda_low = 1'b0;
        hw();
        scl_low = 1'b0;
        hw();
        sda_low = 1'b1;
        hw();
        scl_low = 1'b1;
    endtask : start
    task automatic stop;
        sda_low = 1'b1;
        hw();
        scl_low = 1'b0;
        hw();
        sda_low = 1'b0;
        hw();
    endtask : stop
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
        clk_bit(1'b1, s);
        ack = !s;
    endtask : send_byte
    task automatic recv_byte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            d[i] = s;
        end
        clk_bit(!ack, s);
    endtask : recv_byte
endmodule : i2c_ctrl_model

// ===== i2c_target_wake_sleep_tb_top.sv
// Purpose: self-checking bench of the bus target with wake and sleep
// Assumes: the controller model drives the open-drain lines
// Notes: shortened timeout and stretch counts keep the run brief
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
    checked++; \
    if ((got) !== (ex)) begin \
        num_errors++; \
        $display("wrong value %s exp %0h got %0h", nm, ex, got); \
    end \
end
module i2c_target_wake_sleep_tb_top;
    import i2c_wake_pkg::*;
    localparam int TO = 3000;
    localparam int RAM = 100;
    localparam int EES = 150;
    localparam int EEL = 200;
    logic ref_clk;
    logic reset_n;
    logic scl_out, scl_oe, sda_out, sda_oe, awake;
    logic addr_cfg_valid;
    logic [6:0] addr_cfg;
    logic ee_long_variant;
    logic scl_low, sda_low, scl_w, sda_w;
    reg_write_type reg_write;
    logic [7:0] wr_idx, wr_dat, rd;
    int num_errors = 0;
    int checked = 0;
    ////////////////////////////////////////
    // released lines float up through the pull-ups
    assign scl_w = !((scl_oe && !scl_out) || scl_low);
    assign sda_w = !((sda_oe && !sda_out) || sda_low);
    i2c_target_wake_sleep #(.TIMEOUT_CYCLES(TO), .RAM_WR_CYCLES(RAM),
        .EE_SHORT_CYCLES(EES), .EE_LONG_CYCLES(EEL)) dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .scl_in(scl_w), .sda_in(sda_w),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
        .sda_oe(sda_oe), .addr_cfg_valid(addr_cfg_valid),
        .addr_cfg(addr_cfg), .ee_long_variant(ee_long_variant),
        .awake(awake), .reg_write(reg_write));
    i2c_ctrl_model ctl (.ref_clk(ref_clk), .scl_w(scl_w), .sda_w(sda_w),
        .scl_low(scl_low), .sda_low(sda_low));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // keeps the last stored byte
    always @(posedge ref_clk) begin
        if (reg_write.valid === 1'b1) begin
            wr_idx <= reg_write.index;
            wr_dat <= reg_write.data;
        end
    end
    function automatic logic ok(input int n);
        return ctl.stall >= n - 50 && ctl.stall <= n - 40;
    endfunction : ok
    task automatic wake(input logic [6:0] a);
        logic ack;
        ctl.start();
        ctl.send_byte({a, 1'b0}, ack);
        `CHK("wake ack", 1'b0, ack)
        `CHK("awake", 1'b1, awake)
        ctl.stop();
    endtask : wake
    task automatic t_timeout;
        int n;
        `CHK("asleep at reset", 1'b0, awake)
        wake(7'h68);
        n = 0;
        while (awake === 1'b1 && n < TO + 500) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK("timeout", 1'b1, n >= TO - 60 && n <= TO)
        $display("timeout test done");
    endtask : t_timeout
    task automatic wr_frame(input logic lng, input logic [7:0] idx, dat,
        input int n1, n2, gap);
        logic ack;
        ee_long_variant = lng;
        wake(7'h68);
        repeat (gap) @(negedge ref_clk);
        ctl.start();
        ctl.send_byte(8'hd0, ack);
        `CHK("addr ack", 1'b1, ack)
        ctl.send_byte(idx, ack);
        `CHK("index stall", 0, ctl.stall)
        ctl.send_byte(dat, ack);
        `CHK("stall 1", 1'b1, ok(n1))
        `CHK("store 1", {idx, dat}, {wr_idx, wr_dat})
        ctl.send_byte(~dat, ack);
        `CHK("stall 2", 1'b1, ok(n2))
        `CHK("store 2", {idx + 8'h01, ~dat}, {wr_idx, wr_dat})
        ctl.stop();
        `CHK("asleep after write", 1'b0, awake)
        $display("write test done");
    endtask : wr_frame
    task automatic t_read;
        logic ack;
        wake(7'h68);
        ctl.start();
        ctl.send_byte(8'hd0, ack);
        ctl.send_byte(8'h10, ack);
        ctl.start();
        ctl.send_byte(8'hd1, ack);
        `CHK("read addr ack", 1'b1, ack)
        ctl.recv_byte(1'b1, rd);
        `CHK("read 1", 8'ha5, rd)
        ctl.recv_byte(1'b0, rd);
        `CHK("read 2", 8'h5a, rd)
        ctl.stop();
        `CHK("asleep after read", 1'b0, awake)
        $display("read test done");
    endtask : t_read
    task automatic t_addr;
        logic ack;
        addr_cfg_valid = 1'b1;
        addr_cfg = 7'h7f;
        wake(7'h7f);
        ctl.start();
        ctl.send_byte(8'hd0, ack);
        `CHK("default refused", 1'b0, ack)
        ctl.start();
        ctl.send_byte(8'hfe, ack);
        `CHK("own addr ack", 1'b1, ack)
        ctl.stop();
        $display("address test done");
    endtask : t_addr
    task automatic close_out;
        if (ctl.hung != 0) num_errors++;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    initial begin
        reset_n = 1'b0;
        addr_cfg_valid = 1'b0;
        addr_cfg = 7'h00;
        ee_long_variant = 1'b0;
        repeat (16) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        t_timeout();
        wr_frame(1'b0, 8'h10, 8'ha5, RAM, RAM, TO - 400);
        wr_frame(1'b0, 8'h7f, 8'h3c, RAM, EES, 0);
        wr_frame(1'b1, 8'hff, 8'hc3, EEL, RAM, 0);
        t_read();
        t_addr();
        close_out();
    end
endmodule : i2c_target_wake_sleep_tb_top
